// >>> core/dsp_pkg.sv
// Operation
// - Modes 1,2,3,10,11 run phase correct
// - Non-inverting clears up-match, sets down-match
// - Phase correct peak: fixed, capture or A
// - Peak held one timer tick, then reverse
// - Register peak from 0x0003 to 0xffff
// - Compare match sets channel match flag
// - Overflow flag set at count floor
// - Phase correct loads buffers at peak
// - Fixed peak masks compare writes
// - Peak change via A acts at peak in mode 11, at floor in mode 9; capture acts at once
// - Action two normal, three inverted
// - Pin driven only when direction is output
// - Zero compare low, peak compare high
// - Mode 11 action 1 toggles A
// - Modes 8,9 run frequency correct
// - Frequency correct peak capture or A
// - Frequency correct loads buffers at floor
// - Frequency correct peak flag at peak
// - Frequency correct extremes, mode 9 toggle
// - Prescaler divides by 1,8,64,256,1024
// - Action 0 disconnects; 1 toggles A only, in modes 8 to 11
package dsp_pkg;
   localparam logic [15:0] DSP_PEAK_8 = 16'h00ff;
   localparam logic [15:0] DSP_PEAK_9 = 16'h01ff;
   localparam logic [15:0] DSP_PEAK_10 = 16'h03ff;
   localparam logic [15:0] DSP_MIN_PEAK = 16'h0003;
   localparam logic [15:0] DSP_RST_VAL = 16'h0000;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_CMP_A = 12'h004;
   localparam logic [11:0] OFS_CMP_B = 12'h008;
   localparam logic [11:0] OFS_CAPT = 12'h00c;
   localparam logic [11:0] OFS_CNT = 12'h010;
   localparam logic [11:0] OFS_FLAGS = 12'h014;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_PRE_LSB = 4;
   localparam int CTRL_ACT_A_LSB = 8;
   localparam int CTRL_ACT_B_LSB = 10;
   localparam int CTRL_DIR_A_BIT = 12;
   localparam int CTRL_DIR_B_BIT = 13;
   localparam int FLG_OVF_BIT = 0;
   localparam int FLG_MA_BIT = 1;
   localparam int FLG_MB_BIT = 2;
   localparam int FLG_CAP_BIT = 3;
   typedef enum logic [2:0] {
      DSP_PRE_OFF = 3'h0, DSP_PRE_1 = 3'h1, DSP_PRE_8 = 3'h2,
      DSP_PRE_64 = 3'h3, DSP_PRE_256 = 3'h4, DSP_PRE_1024 = 3'h5
   } dsp_pre_e;
   typedef enum logic {DSP_UP = 1'b0, DSP_DOWN = 1'b1} dsp_dir_e;
endpackage

// >>> core/dsp_timer.sv
`timescale 1ns/1ps
module dsp_timer (
   input wire logic mclk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic chan_a_pin_out,
   output logic chan_a_pin_oe,
   output logic chan_b_pin_out,
   output logic chan_b_pin_oe
);
   import dsp_pkg::*;

   logic [15:0] ctrl_reg;
   logic [15:0] cmp_a_buf_reg, cmp_b_buf_reg, cmp_a_reg, cmp_b_reg;
   logic [15:0] capt_reg, counter_value_reg;
   dsp_dir_e dir_reg;
   logic [3:0] flags_reg;
   logic [9:0] pre_cnt_reg;
   logic out_a_reg, out_b_reg;
   logic tick;
   logic [3:0] waveform_mode_sel;
   logic [1:0] act_a, act_b;
   logic phase_correct, freq_correct, dual_mode, fixed_peak;
   logic [15:0] peak, mask;
   logic at_peak, at_floor, match_a, match_b;
   logic count_down;
   logic wr_en, rd_en;
   logic [3:0] flag_set, flag_clr;

   assign waveform_mode_sel = ctrl_reg[CTRL_MODE_LSB +: 4];
   assign act_a = ctrl_reg[CTRL_ACT_A_LSB +: 2];
   assign act_b = ctrl_reg[CTRL_ACT_B_LSB +: 2];

   function automatic logic [15:0] fixed_mask(input logic [3:0] m);
      unique case (m)
         4'h1: fixed_mask = DSP_PEAK_8;
         4'h2: fixed_mask = DSP_PEAK_9;
         4'h3: fixed_mask = DSP_PEAK_10;
         default: fixed_mask = 16'hffff;
      endcase
   endfunction

   // Mode decode
   assign phase_correct = (waveform_mode_sel inside {4'h1, 4'h2, 4'h3,
      4'ha, 4'hb});
   assign freq_correct = (waveform_mode_sel inside {4'h8, 4'h9});
   assign dual_mode = phase_correct | freq_correct;
   assign fixed_peak = (waveform_mode_sel inside {4'h1, 4'h2, 4'h3});
   assign mask = fixed_mask(waveform_mode_sel);

   always_comb begin
      unique case (waveform_mode_sel)
         4'ha, 4'h8: peak = capt_reg;
         4'hb, 4'h9: peak = cmp_a_reg;
         default: peak = mask;
      endcase
   end

   // Prescaler: tick is the timer clock enable
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         pre_cnt_reg <= 10'h000;
      end else begin
         pre_cnt_reg <= pre_cnt_reg + 10'h001;
      end
   end

   always_comb begin
      unique case (ctrl_reg[CTRL_PRE_LSB +: 3])
         DSP_PRE_1: tick = 1'b1;
         DSP_PRE_8: tick = (pre_cnt_reg[2:0] == 3'h7);
         DSP_PRE_64: tick = (pre_cnt_reg[5:0] == 6'h3f);
         DSP_PRE_256: tick = (pre_cnt_reg[7:0] == 8'hff);
         DSP_PRE_1024: tick = (pre_cnt_reg == 10'h3ff);
         default: tick = 1'b0;
      endcase
   end

   assign at_peak = (counter_value_reg == peak);
   assign at_floor = (counter_value_reg == DSP_RST_VAL);
   assign match_a = (counter_value_reg == cmp_a_reg);
   assign match_b = (counter_value_reg == cmp_b_reg);
   // Floor counts as up slope, peak as down slope, so extremes stay flat
   assign count_down = !at_floor && (dir_reg == DSP_DOWN || at_peak);

   // Counter and direction; peak value sits one tick before reversal
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         counter_value_reg <= DSP_RST_VAL;
         dir_reg <= DSP_UP;
      end else if (wr_en && paddr == OFS_CNT) begin
         counter_value_reg <= pwdata[15:0];
         dir_reg <= DSP_UP;
      end else if (tick && dual_mode) begin
         if (dir_reg == DSP_UP) begin
            if (at_peak) begin
               dir_reg <= DSP_DOWN;
               counter_value_reg <= counter_value_reg - 16'h0001;
            end else begin
               counter_value_reg <= counter_value_reg + 16'h0001;
            end
         end else if (at_floor) begin
            dir_reg <= DSP_UP;
            counter_value_reg <= counter_value_reg + 16'h0001;
         end else begin
            counter_value_reg <= counter_value_reg - 16'h0001;
         end
      end
   end

   // Double buffered compares; capture register defines peak directly
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cmp_a_buf_reg <= DSP_RST_VAL;
         cmp_b_buf_reg <= DSP_RST_VAL;
         capt_reg <= DSP_RST_VAL;
      end else if (wr_en) begin
         if (paddr == OFS_CMP_A)
            cmp_a_buf_reg <= pwdata[15:0] & mask;
         if (paddr == OFS_CMP_B)
            cmp_b_buf_reg <= pwdata[15:0] & mask;
         if (paddr == OFS_CAPT)
            capt_reg <= pwdata[15:0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         cmp_a_reg <= DSP_RST_VAL;
         cmp_b_reg <= DSP_RST_VAL;
      end else if (tick && ((phase_correct && at_peak && dir_reg == DSP_UP)
         || (freq_correct && at_floor && dir_reg == DSP_DOWN))) begin
         cmp_a_reg <= cmp_a_buf_reg;
         cmp_b_reg <= cmp_b_buf_reg;
      end
   end

   // Flag events
   always_comb begin
      flag_set = 4'h0;
      if (tick && dual_mode) begin
         flag_set[FLG_OVF_BIT] = at_floor && dir_reg == DSP_DOWN;
         flag_set[FLG_MA_BIT] = match_a;
         flag_set[FLG_MB_BIT] = match_b;
         flag_set[FLG_CAP_BIT] = at_peak && dir_reg == DSP_UP &&
            (waveform_mode_sel inside {4'ha, 4'h8});
         if (at_peak && dir_reg == DSP_UP &&
            (waveform_mode_sel inside {4'hb, 4'h9}))
            flag_set[FLG_MA_BIT] = 1'b1;
      end
   end

   // Write one to clear; a set in the same cycle wins
   assign flag_clr = (wr_en && paddr == OFS_FLAGS) ? pwdata[3:0] : 4'h0;

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         flags_reg <= 4'h0;
      end else begin
         flags_reg <= (flags_reg & ~flag_clr) | flag_set;
      end
   end

   // Waveform: up-match clears, down-match sets for non-inverting
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         out_a_reg <= 1'b0;
      end else if (tick && dual_mode && match_a) begin
         if (act_a == 2'h1 && waveform_mode_sel[3])
            out_a_reg <= ~out_a_reg;
         else if (act_a[1])
            out_a_reg <= count_down ^ act_a[0];
      end
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         out_b_reg <= 1'b0;
      end else if (tick && dual_mode && match_b && act_b[1]) begin
         out_b_reg <= count_down ^ act_b[0];
      end
   end

   // Toggle on A only in modes 8 to 11; B never toggles
   assign chan_a_pin_out = out_a_reg;
   assign chan_a_pin_oe = ctrl_reg[CTRL_DIR_A_BIT] && dual_mode &&
      (act_a[1] || (act_a == 2'h1 &&
      waveform_mode_sel[3]));
   assign chan_b_pin_out = out_b_reg;
   assign chan_b_pin_oe = ctrl_reg[CTRL_DIR_B_BIT] && dual_mode &&
      act_b[1];

   // APB slave, zero wait states
   assign pready = 1'b1;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;

   always_comb begin
      unique case (paddr)
         OFS_CTRL, OFS_CMP_A, OFS_CMP_B, OFS_CAPT, OFS_CNT, OFS_FLAGS:
            pslverr = 1'b0;
         default: pslverr = psel && penable;
      endcase
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_reg <= DSP_RST_VAL;
      end else if (wr_en && paddr == OFS_CTRL) begin
         ctrl_reg <= {2'h0, pwdata[13:0]};
      end
   end

   always_comb begin
      unique case (paddr)
         OFS_CTRL: prdata = {16'h0000, ctrl_reg};
         OFS_CMP_A: prdata = {16'h0000, cmp_a_buf_reg};
         OFS_CMP_B: prdata = {16'h0000, cmp_b_buf_reg};
         OFS_CAPT: prdata = {16'h0000, capt_reg};
         OFS_CNT: prdata = {16'h0000, counter_value_reg};
         OFS_FLAGS: prdata = {28'h0000000, flags_reg};
         default: prdata = 32'h00000000;
      endcase
   end

   cnt_peak_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && dual_mode && dir_reg == DSP_UP && at_peak &&
      !(wr_en && paddr == OFS_CNT) |=> dir_reg == DSP_DOWN &&
      counter_value_reg == $past(counter_value_reg) - 16'h0001)
      else $error("peak not reversed");
   ovf_floor_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && dual_mode && at_floor && dir_reg == DSP_DOWN
      |=> flags_reg[FLG_OVF_BIT])
      else $error("overflow flag missed");
   pc_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && phase_correct && at_peak && dir_reg == DSP_UP
      |=> cmp_b_reg == $past(cmp_b_buf_reg))
      else $error("peak load missed");
   pfc_load_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && freq_correct && at_floor && dir_reg == DSP_DOWN
      |=> cmp_b_reg == $past(cmp_b_buf_reg))
      else $error("floor load missed");
   match_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && dual_mode && match_b |=> flags_reg[FLG_MB_BIT])
      else $error("match flag missed");
   mask_write_a: assert property (@(posedge mclk) disable iff (!reset_n)
      wr_en && paddr == OFS_CMP_B && fixed_peak
      |=> (cmp_b_buf_reg & ~$past(mask)) == 16'h0000)
      else $error("mask not applied");
   pin_dir_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !ctrl_reg[CTRL_DIR_A_BIT] |-> !chan_a_pin_oe)
      else $error("pin driven as input");
   wave_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && dual_mode && match_b && act_b == 2'h2 &&
      count_down |=> out_b_reg)
      else $error("down match not set");
   wave_clr_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && dual_mode && match_b && act_b == 2'h2 &&
      !count_down |=> !out_b_reg)
      else $error("up match not cleared");
   inv_set_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && dual_mode && match_b && act_b == 2'h3 &&
      !count_down |=> out_b_reg)
      else $error("inverted up match not set");
   toggle_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && dual_mode && match_a && act_a == 2'h1 &&
      waveform_mode_sel[3] |=> out_a_reg != $past(out_a_reg))
      else $error("toggle missed");
   disc_b_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !act_b[1] |-> !chan_b_pin_oe)
      else $error("channel b not disconnected");
   floor_turn_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && dual_mode && dir_reg == DSP_DOWN && at_floor &&
      !(wr_en && paddr == OFS_CNT) |=> dir_reg == DSP_UP)
      else $error("floor not reversed");
   fixed_peak_a: assert property (@(posedge mclk) disable iff (!reset_n)
      waveform_mode_sel == 4'h1 |-> peak == DSP_PEAK_8)
      else $error("fixed peak wrong");
   pre_off_a: assert property (@(posedge mclk) disable iff (!reset_n)
      ctrl_reg[CTRL_PRE_LSB +: 3] == DSP_PRE_OFF |-> !tick)
      else $error("tick while stopped");
   inverted_c: cover property (@(posedge mclk) disable iff (!reset_n)
      tick && match_b && act_b == 2'h3);
   idle_hold_a: assert property (@(posedge mclk) disable iff (!reset_n)
      !tick && !wr_en |=> $stable(counter_value_reg))
      else $error("counter moved without tick");
   cap_flag_a: assert property (@(posedge mclk) disable iff (!reset_n)
      tick && waveform_mode_sel == 4'h8 && at_peak && dir_reg == DSP_UP
      |=> flags_reg[FLG_CAP_BIT])
      else $error("capture flag missed");
   peak_c: cover property (@(posedge mclk) disable iff (!reset_n)
      tick && phase_correct && at_peak && dir_reg == DSP_UP);
   floor_c: cover property (@(posedge mclk) disable iff (!reset_n)
      tick && freq_correct && at_floor && dir_reg == DSP_DOWN);
   toggle_c: cover property (@(posedge mclk) disable iff (!reset_n)
      tick && match_a && act_a == 2'h1 && waveform_mode_sel == 4'hb);
endmodule

// >>> dv/dsp_pin_load.sv
`timescale 1ns/1ps
module dsp_pin_load (
   input wire logic pin_out,
   input wire logic pin_oe,
   output logic pin_level
);
   // Load has a pull-down, so a released pin settles low
   assign pin_level = pin_oe ? pin_out : 1'b0;
endmodule

// >>> dv/dual_slope_pwm_timer_tb.sv
`timescale 1ns/1ps
module dual_slope_pwm_timer_tb;
   import dsp_pkg::*;
   logic mclk, reset_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic a_out, a_oe, b_out, b_oe, a_lvl, b_lvl;
   int err_count, checks;
   dsp_timer dut (.mclk(mclk), .reset_n(reset_n), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .chan_a_pin_out(a_out), .chan_a_pin_oe(a_oe),
      .chan_b_pin_out(b_out), .chan_b_pin_oe(b_oe));
   dsp_pin_load pa (.pin_out(a_out), .pin_oe(a_oe), .pin_level(a_lvl));
   dsp_pin_load pb (.pin_out(b_out), .pin_oe(b_oe), .pin_level(b_lvl));
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // Called just after an edge; leaves one idle cycle behind it
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d);
      int n;
      logic rdy;
      n = 0;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      // Answer is settled mid-cycle and unchanged up to the access edge
      do begin
         @(negedge mclk);
         rd = prdata;
         err = pslverr;
         rdy = pready;
         @(posedge mclk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1) begin
         err_count++;
         results();
      end
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask
   task automatic poll_cnt(input logic [15:0] v);
      int n;
      n = 0;
      do begin
         apb(1'b0, OFS_CNT, 32'h0);
         n++;
      end while (rd[15:0] !== v && n < 40);
      if (rd[15:0] !== v) begin
         err_count++;
         results();
      end
   endtask
   function automatic logic [31:0] ctrl(input logic [3:0] m,
      input logic [2:0] p, input logic [1:0] aa, input logic [1:0] ab,
      input logic da, input logic db);
      return {18'h0, db, da, ab, aa, 1'b0, p, m};
   endfunction
   task automatic t_reset;
      chk({28'h0, a_oe, b_oe, a_out, b_out}, 32'h0);
      for (int i = 0; i < 6; i++) rdc(12'(4 * i), 32'h0);
      wr(12'h018, 32'h1);
      chk(err, 1'b1);
      rdc(12'h018, 32'h0);
      chk(err, 1'b1);
   endtask
   task automatic t_mask;
      logic [15:0] pk [4];
      pk = '{DSP_PEAK_8, DSP_PEAK_9, DSP_PEAK_10, 16'hffff};
      for (int i = 0; i < 4; i++) begin
         wr(OFS_CTRL, ctrl((i < 3) ? 4'(i + 1) : 4'ha, DSP_PRE_OFF, 0, 0, 0, 0));
         wr(OFS_CMP_A, 32'hffffffff);
         rdc(OFS_CMP_A, {16'h0, pk[i]});
         wr(OFS_CMP_B, 32'h0000ffff);
         rdc(OFS_CMP_B, {16'h0, pk[i]});
      end
   endtask
   // Samples every 3 cycles over a 10 cycle period hit each phase 3 times
   task automatic t_slope;
      int n5, n4, n0, mx;
      n5 = 0; n4 = 0; n0 = 0; mx = 0;
      wr(OFS_CTRL, ctrl(4'ha, DSP_PRE_OFF, 0, 0, 0, 0));
      wr(OFS_CAPT, 32'h5);
      wr(OFS_CNT, 32'h0);
      wr(OFS_CTRL, ctrl(4'ha, DSP_PRE_1, 0, 0, 0, 0));
      repeat (30) begin
         apb(1'b0, OFS_CNT, 32'h0);
         n5 += (rd === 32'h5);
         n4 += (rd === 32'h4);
         n0 += (rd === 32'h0);
         if (rd[15:0] > mx) mx = rd[15:0];
      end
      chk(n5, 3);
      chk(n4, 6);
      chk(n0, 3);
      chk(mx, 5);
   endtask
   task automatic t_pre;
      int nn [5];
      logic [31:0] c0;
      nn = '{1, 8, 64, 256, 1024};
      wr(OFS_CAPT, 32'hffff);
      for (int i = 0; i < 6; i++) begin
         wr(OFS_CTRL, ctrl(4'ha, (i < 5) ? 3'(i + 1) : 3'h0, 0, 0, 0, 0));
         wr(OFS_CNT, 32'h0);
         apb(1'b0, OFS_CNT, 32'h0);
         c0 = rd;
         repeat (4 * ((i < 5) ? nn[i] : 1) - 3) @(posedge mclk);
         apb(1'b0, OFS_CNT, 32'h0);
         chk(rd - c0, (i < 5) ? 32'h4 : 32'h0);
      end
   endtask
   task automatic t_flags(input logic [3:0] m);
      wr(OFS_CTRL, ctrl(m, DSP_PRE_OFF, 0, 0, 0, 0));
      wr(OFS_CAPT, 32'h7);
      wr(OFS_CMP_B, 32'h3);
      wr(OFS_CNT, 32'h6);
      wr(OFS_FLAGS, 32'hf);
      wr(OFS_CTRL, ctrl(m, DSP_PRE_8, 0, 0, 0, 0));
      // Flags rise as the count leaves peak or floor
      poll_cnt(16'h7);
      poll_cnt(16'h6);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd & 32'h9, 32'h8);
      poll_cnt(16'h0);
      poll_cnt(16'h1);
      apb(1'b0, OFS_FLAGS, 32'h0);
      chk(rd & 32'hd, 32'hd);
   endtask
   task automatic t_pwm(input logic [3:0] m, input logic [1:0] aa,
      input logic [1:0] ab, input logic da, input logic db,
      input logic [31:0] ca, input logic [31:0] cb, input int len,
      input int ea, input int eb, input logic [1:0] oe);
      int ha, hb;
      wr(OFS_CTRL, ctrl(m, DSP_PRE_1, aa, ab, da, db));
      wr(OFS_CNT, 32'h0);
      wr(OFS_CAPT, 32'h7);
      wr(OFS_CMP_A, ca);
      wr(OFS_CMP_B, cb);
      repeat (3 * len) @(posedge mclk);
      ha = 0;
      hb = 0;
      repeat (len) begin
         @(posedge mclk);
         ha += (a_lvl === 1'b1);
         hb += (b_lvl === 1'b1);
      end
      chk(ha, ea);
      chk(hb, eb);
      chk({a_oe, b_oe}, oe);
   endtask
   initial begin
      reset_n = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      err_count = 0;
      checks = 0;
      repeat (4) @(posedge mclk);
      reset_n <= 1'b1;
      @(posedge mclk);
      t_reset();
      t_mask();
      t_slope();
      t_pre();
      t_flags(4'ha);
      t_flags(4'h8);
      t_pwm(4'ha, 2, 3, 1, 1, 2, 3, 56, 16, 32, 2'b11);
      t_pwm(4'h8, 2, 2, 1, 1, 7, 0, 56, 56, 0, 2'b11);
      t_pwm(4'hb, 1, 1, 1, 1, 7, 3, 56, 28, 0, 2'b10);
      t_pwm(4'h9, 1, 2, 1, 1, 7, 5, 56, 28, 40, 2'b11);
      t_pwm(4'h1, 0, 3, 1, 1, 0, 32'h80, 510, 0, 254, 2'b01);
      t_pwm(4'ha, 2, 2, 0, 1, 2, 3, 56, 0, 24, 2'b01);
      results();
   end
endmodule
